// ### bench/bmo_ctrl_model.sv
// Behavioural microprogram controller driving the slice's instruction lines.
module bmo_ctrl_model
(
	// Clock.
	input wire logic clk_i,
	// Instruction lines.
	output logic valid_o,
	output logic [7:0] instr_o,
	output logic [5:0] s_addr_o,
	output logic [5:0] r_addr_o,
	output logic [5:0] d_addr_o,
	output logic [3:0] byte_shift_io_n_o,
	output logic csf_o,
	output logic carry_input_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Lines idle at time zero.
	initial
	begin
		valid_o = 1'b0;
		{instr_o, s_addr_o, r_addr_o, d_addr_o, byte_shift_io_n_o, csf_o, carry_input_o} = '0;
	end

	// Drives one instruction for one cycle; bit ops get defined select and carry levels.
	task automatic issue(input logic [7:0] ins, input logic [5:0] s, input logic [5:0] r,
		input logic [5:0] d, input logic [3:0] bsel_n, input logic csf, input logic carry);
		logic bitop;
		bitop = (ins == 8'h18) || (ins == 8'h08);
		valid_o <= 1'b1;
		instr_o <= ins;
		s_addr_o <= s;
		r_addr_o <= r;
		d_addr_o <= d;
		byte_shift_io_n_o <= bsel_n;
		csf_o <= bitop ? 1'b1 : csf;
		carry_input_o <= bitop ? 1'b0 : carry;
		@(posedge clk_i);
	endtask

	// Releases the lines; inverted values keep stale operands from looking valid.
	task automatic idle();
		valid_o <= 1'b0;
		instr_o <= ~instr_o;
		s_addr_o <= ~s_addr_o;
		r_addr_o <= ~r_addr_o;
		d_addr_o <= ~d_addr_o;
		byte_shift_io_n_o <= ~byte_shift_io_n_o;
		@(posedge clk_i);
	endtask
endmodule

// ### bench/bmo_top_sva.sv
// Port-level checker of the bit-op ALU slice with its bind.
module bmo_top_sva
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Instruction lines.
	input wire logic instr_valid_i,
	input wire logic [7:0] instr_i,
	input wire logic [3:0] r_operand_address_low_i,
	input wire logic [3:0] dest_address_low_i,
	input wire logic [3:0] byte_shift_io_n_i,
	input wire logic conditional_select_flag_i,
	// Results and register port.
	input wire logic [31:0] y_o,
	input wire logic [7:0] rbus_o,
	input wire logic zero_flag_o,
	input wire logic negative_flag_o,
	input wire logic overflow_flag_o,
	input wire logic carry_flag_o,
	input wire logic done_o,
	input wire logic [9:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	// Instruction decode as seen from the pins.
	logic is_bit;
	logic is_shl;
	logic legal;
	logic [7:0] mask;
	assign is_bit = instr_valid_i && (instr_i == 8'h18 || instr_i == 8'h08);
	assign is_shl = instr_valid_i && instr_i[7:4] == 4'h6;
	assign legal = is_bit || is_shl;
	assign mask = {dest_address_low_i, r_operand_address_low_i};

	// True when every selected byte shows the masked bits at the given level.
	function automatic logic bytes_ok(input logic [31:0] y, input logic [7:0] m,
		input logic [3:0] sel_n, input logic set);
		for (int b = 0; b < 4; b++)
			if (!sel_n[b] && ((y[8*b+:8] & m) != (set ? m : 8'h00)))
				return 1'b0;
		return 1'b1;
	endfunction

	// True when all selected bytes are zero.
	function automatic logic sel_zero(input logic [31:0] y, input logic [3:0] sel_n);
		for (int b = 0; b < 4; b++)
			if (!sel_n[b] && y[8*b+:8] != 8'h00)
				return 1'b0;
		return 1'b1;
	endfunction

	a_clr_mask_bits: assert property (instr_valid_i && instr_i == 8'h18 |=>
		bytes_ok(y_o, $past(mask), $past(byte_shift_io_n_i), 1'b0))
		else $error("bit clear left masked bits set");
	a_set_mask_bits: assert property (instr_valid_i && instr_i == 8'h08 |=>
		bytes_ok(y_o, $past(mask), $past(byte_shift_io_n_i), 1'b1))
		else $error("bit set left masked bits clear");
	a_rbus_mask: assert property (is_bit |=> rbus_o == $past(mask))
		else $error("mask bus wrong");
	a_bitop_flags: assert property (is_bit ##1 1'b1 |->
		!negative_flag_o && !overflow_flag_o && !carry_flag_o
		&& zero_flag_o == sel_zero(y_o, $past(byte_shift_io_n_i)))
		else $error("bit op flags wrong");
	a_done_pulse: assert property (legal |=> done_o)
		else $error("done missing");
	a_no_done: assert property (!legal |=> !done_o)
		else $error("done without instruction");
	a_shift_fill: assert property (is_shl && conditional_select_flag_i |=>
		y_o[0] == !$past(byte_shift_io_n_i[0]))
		else $error("shift fill bit wrong");
	a_shift_flags: assert property (is_shl |=>
		zero_flag_o == (y_o == 32'h0) && negative_flag_o == y_o[31])
		else $error("shift zero or negative flag wrong");
	a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
		else $error("read data outside read cycle");
	a_flags_read: assert property (reg_rd_i && reg_addr_i == 10'h004 |=>
		reg_rdata_o == {28'h0, $past({carry_flag_o, overflow_flag_o,
		negative_flag_o, zero_flag_o})})
		else $error("flag register read wrong");
endmodule

bind bmo_top bmo_top_sva chk (.clk_i, .rst_b_i, .instr_valid_i, .instr_i,
	.r_operand_address_low_i, .dest_address_low_i, .byte_shift_io_n_i,
	.conditional_select_flag_i, .y_o, .rbus_o, .zero_flag_o, .negative_flag_o,
	.overflow_flag_o, .carry_flag_o, .done_o, .reg_addr_i, .reg_rd_i, .reg_rdata_o);

// ### bench/tb.sv
// Self-checking testbench of the bit-op ALU slice.
`include "bmo_consts.svh"
module tb
	import bmo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i;
	logic rst_b_i;
	logic instr_valid_i;
	logic [7:0] instr_i;
	logic [5:0] s_a;
	logic [5:0] r_a;
	logic [5:0] d_a;
	logic [3:0] bsel_n;
	logic csf;
	logic carry;
	logic [31:0] y_o;
	logic [7:0] rbus_o;
	logic zero_flag_o;
	logic negative_flag_o;
	logic overflow_flag_o;
	logic carry_flag_o;
	logic done_o;
	logic [9:0] reg_addr_i = 10'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic irq_o;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;

	bmo_ctrl_model ctl (.clk_i, .valid_o(instr_valid_i), .instr_o(instr_i), .s_addr_o(s_a),
		.r_addr_o(r_a), .d_addr_o(d_a), .byte_shift_io_n_o(bsel_n), .csf_o(csf),
		.carry_input_o(carry));

	bmo_top dut (.clk_i, .rst_b_i, .instr_valid_i, .instr_i, .s_operand_address_i(s_a),
		.r_operand_address_high_i(r_a[5:4]), .r_operand_address_low_i(r_a[3:0]),
		.dest_address_high_i(d_a[5:4]), .dest_address_low_i(d_a[3:0]),
		.byte_shift_io_n_i(bsel_n), .conditional_select_flag_i(csf), .carry_input_i(carry),
		.y_o, .rbus_o, .zero_flag_o, .negative_flag_o, .overflow_flag_o, .carry_flag_o,
		.done_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);

	// Clock of 50 ns period.
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// Cuts a hang short.
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			miscompares++;
			close_out();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	// One register write, strobe dropped for a cycle after.
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// One register read; data is looked at in the cycle after the strobe.
	task automatic rd(input logic [9:0] a, input logic [31:0] e, input string n);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(n, e, reg_rdata_o);
		@(posedge clk_i);
	endtask

	// Executes one instruction and compares result and flags.
	task automatic ex(input logic [7:0] ins, input logic [5:0] s, input logic [5:0] r,
		input logic [5:0] d, input logic [3:0] bs, input logic sf, input logic c,
		input logic [31:0] ey, input logic [3:0] ef);
		ctl.issue(ins, s, r, d, bs, sf, c);
		ctl.idle();
		chk("y_o", ey, y_o);
		chk("flags", {28'h0, ef}, {28'h0, carry_flag_o, overflow_flag_o,
			negative_flag_o, zero_flag_o});
	endtask

	// Main sequence.
	initial
	begin
		rst_b_i = 1'b0;
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rd(`BMO_ADDR_CTRL, 32'h2, "ctrl");
		rd(`BMO_ADDR_IRQ_MASK, 32'h0, "irq_mask");
		rd(`BMO_ADDR_FLAGS, 32'h0, "flags");
		rd(`BMO_ADDR_RF_BASE + 10'h01c, 32'h0, "rf7");
		wr(10'h020, 32'hffffffff);
		rd(10'h020, 32'h0, "unmapped");
		$display("test reset done");
		wr(`BMO_ADDR_RF_BASE + 10'h020, 32'ha083bebe);
		ex(8'h18, 6'd8, 6'h0f, 6'h00, 4'b1001, 1'b0, 1'b0, 32'ha080b0be, 4'h0);
		rd(`BMO_ADDR_RF_BASE + 10'h020, 32'ha080b0be, "rf8");
		wr(`BMO_ADDR_RF_BASE + 10'h004, 32'ha083bebe);
		ex(8'h08, 6'd1, 6'h0f, 6'h00, 4'b1101, 1'b0, 1'b0, 32'ha083bfbe, 4'h0);
		wr(`BMO_ADDR_RF_BASE + 10'h008, 32'h12345678);
		ex(8'h18, 6'd2, 6'h0f, 6'h0f, 4'b0000, 1'b0, 1'b0, 32'h0, 4'h1);
		$display("test bit ops done");
		wr(`BMO_ADDR_RF_BASE + 10'h004, 32'h1308c618);
		wr(`BMO_ADDR_RF_BASE + 10'h008, 32'h44007530);
		ex(8'h60, 6'd2, 6'd1, 6'd5, 4'b1110, 1'b1, 1'b0, 32'hae127691, 4'h6);
		ctl.issue(8'h60, 6'd2, 6'd1, 6'd5, 4'b1110, 1'b0, 1'b0);
		ex(8'h63, 6'd5, 6'd1, 6'd6, 4'b1111, 1'b1, 1'b1, 32'hae127692, 4'h6);
		rd(`BMO_ADDR_RF_BASE + 10'h014, 32'h57093b48, "rf5");
		rd(`BMO_ADDR_RESULT, 32'hae127692, "result");
		wr(`BMO_ADDR_RF_BASE + 10'h00c, 32'hffffffff);
		wr(`BMO_ADDR_RF_BASE + 10'h010, 32'h1);
		ex(8'h60, 6'd4, 6'd3, 6'd7, 4'b1111, 1'b1, 1'b1, 32'h2, 4'h8);
		wr(`BMO_ADDR_CTRL, 32'h0);
		wr(`BMO_ADDR_RF_BASE + 10'h018, 32'h80808080);
		ex(8'h63, 6'd6, 6'd0, 6'd7, 4'b0101, 1'b1, 1'b0, 32'h01000100, 4'h4);
		wr(`BMO_ADDR_CTRL, 32'h3);
		rd(`BMO_ADDR_CTRL, 32'h0, "ctrl");
		wr(`BMO_ADDR_CTRL, 32'h2);
		$display("test shift done");
		wr(`BMO_ADDR_IRQ_STAT, 32'h7);
		rd(`BMO_ADDR_IRQ_STAT, 32'h0, "irq_stat");
		wr(`BMO_ADDR_IRQ_MASK, 32'h4);
		chk("irq_o", 32'h0, {31'h0, irq_o});
		ctl.issue(8'hff, 6'd7, 6'd0, 6'd0, 4'b0000, 1'b1, 1'b0);
		ctl.idle();
		chk("y_o", 32'h01000100, y_o);
		rd(`BMO_ADDR_IRQ_STAT, 32'h4, "irq_stat");
		chk("irq_o", 32'h1, {31'h0, irq_o});
		wr(`BMO_ADDR_IRQ_MASK, 32'h1);
		chk("irq_o", 32'h0, {31'h0, irq_o});
		ex(8'h08, 6'd7, 6'h0f, 6'h00, 4'b0000, 1'b0, 1'b0, 32'h0f0f0f0f, 4'h0);
		rd(`BMO_ADDR_IRQ_STAT, 32'h5, "irq_stat");
		chk("irq_o", 32'h1, {31'h0, irq_o});
		wr(`BMO_ADDR_IRQ_STAT, 32'h5);
		rd(`BMO_ADDR_IRQ_STAT, 32'h0, "irq_stat");
		chk("irq_o", 32'h0, {31'h0, irq_o});
		$display("test interrupt done");
		close_out();
	end
endmodule

// ### design/bmo_alu.sv
// Byte-sliced ALU with carry chains broken at word boundaries.
module bmo_alu
	import bmo_pkg::*;
(
	// Operands and control.
	input wire logic [31:0] r_i,
	input wire logic [31:0] s_i,
	input wire logic [3:0] op_i,
	input wire logic carry_input_i,
	input wire bmo_wsize_e wsize_i,
	// Result and status of the most significant word.
	output logic [31:0] f_o,
	output logic cout_o,
	output logic ovf_o
);

	logic [31:0] x;
	logic [31:0] y;
	logic [31:0] sum;
	logic [31:0] logic_f;
	logic [4:0] c;
	logic arith;

	// Operand selection and the logic functions.
	always_comb
	begin
		x = r_i;
		y = s_i;
		arith = 1'b1;
		logic_f = '0;
		unique case (op_i)
			4'h0: ;
			4'h1: x = ~r_i;
			4'h2: y = ~s_i;
			4'h3: x = '0;
			4'h4: begin x = '0; y = ~s_i; end
			4'h5: y = '0;
			4'h6: begin x = ~r_i; y = '0; end
			4'h9: begin arith = 1'b0; logic_f = r_i ^ s_i; end
			4'ha: begin arith = 1'b0; logic_f = r_i & s_i; end
			4'hb: begin arith = 1'b0; logic_f = r_i | s_i; end
			4'hc: begin arith = 1'b0; logic_f = ~(r_i & s_i); end
			4'hd: begin arith = 1'b0; logic_f = ~(r_i | s_i); end
			4'he: begin arith = 1'b0; logic_f = ~r_i & s_i; end
			default: arith = 1'b0;
		endcase
	end

	// Each byte adds its slice; a word's lowest byte takes the carry input.
	assign c[0] = carry_input_i;
	for (genvar b = 0; b < 4; b++)
	begin : g_byte
		logic cin;
		assign cin = bmo_word_lsb(b, wsize_i) ? carry_input_i : c[b];
		assign {c[b+1], sum[8*b+7:8*b]} = {1'b0, x[8*b+7:8*b]} + {1'b0, y[8*b+7:8*b]}
			+ {8'h00, cin};
	end

	assign f_o = arith ? sum : logic_f;
	// Status is taken from the top word, whose top byte is byte 3.
	assign cout_o = arith & c[4];
	assign ovf_o = arith & (x[31] == y[31]) & (sum[31] != x[31]);

endmodule

// ### design/bmo_regfile.sv
// Sixty-four word register file with three read ports and one write port.
module bmo_regfile
	import bmo_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Core side.
	bmo_rf_if.file rf
);

	typedef struct packed {
		logic [63:0][31:0] mem;
	} bmo_rf_s;

	bmo_rf_s st_ff;
	bmo_rf_s nxt_st;

	// Reads are asynchronous so an operand is seen in the cycle it is addressed.
	assign rf.ra_data = st_ff.mem[rf.ra_addr];
	assign rf.sa_data = st_ff.mem[rf.sa_addr];
	assign rf.ba_data = st_ff.mem[rf.ba_addr];

	// Write port update.
	always_comb
	begin
		nxt_st = st_ff;
		if (rf.we)
		begin
			nxt_st.mem[rf.wa] = rf.wd;
		end
	end

	// State register, cleared by reset.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

endmodule

// ### design/bmo_top.sv
// Masked bit-clear/bit-set and conditional arithmetic left shift slice of a registered ALU.
//
// Summary of operation
// - Bit ops read the S-address word and write the result back there.
// - Mask is destination nibble over R-address nibble, presented on the R bus.
// - Bit-clear zeroes masked operand bits only in bytes whose line is low.
// - Bit-set forces masked bits to one only in bytes whose line is low.
// - In a bit op, a byte whose shift-I/O line is high passes the S byte unchanged.
// - Bit ops: zero flag from selected bytes; negative, overflow, carry cleared.
// - Shift computes the low-nibble ALU operation, then shifts it left once.
// - Each word's lowest bit fills zero, or one when its line is low.
// - Bit 7 of each word's top byte drops out; words are 1, 2 or 4 bytes.
// - Select flag high gives shifted result, low gives unshifted ALU result.
// - Carry input feeds the ALU arithmetic ahead of the shift as usual.
// - Shift carry flag is the ALU carry-out before shifting.
// - Shift zero and negative flags come from the written result, shifted or unshifted.
// - Shift overflow is ALU signed overflow or top two bits differing.
module bmo_top
	import bmo_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Instruction from the microprogram controller.
	input wire logic instr_valid_i,
	input wire logic [7:0] instr_i,
	input wire logic [5:0] s_operand_address_i,
	input wire logic [1:0] r_operand_address_high_i,
	input wire logic [3:0] r_operand_address_low_i,
	input wire logic [1:0] dest_address_high_i,
	input wire logic [3:0] dest_address_low_i,
	input wire logic [3:0] byte_shift_io_n_i,
	input wire logic conditional_select_flag_i,
	input wire logic carry_input_i,
	// Results and status.
	output logic [31:0] y_o,
	output logic [7:0] rbus_o,
	output logic zero_flag_o,
	output logic negative_flag_o,
	output logic overflow_flag_o,
	output logic carry_flag_o,
	output logic done_o,
	// Register port.
	input wire logic [9:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Interrupt.
	output logic irq_o
);

	`include "bmo_consts.svh"

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	bmo_rf_if rf ();

	bmo_top_s st_ff;
	bmo_top_s nxt_st;

	bmo_kind_e kind;
	logic [7:0] mask;
	logic [31:0] s_word;
	logic [31:0] alu_f;
	logic alu_cout;
	logic alu_ovf;
	logic [31:0] bit_res;
	logic [31:0] shl_res;
	logic [31:0] op_res;
	logic [3:0] sel;
	logic [3:0] sel_zero;
	logic [3:0] op_flags;
	logic [2:0] events;
	logic rf_hit;
	logic [31:0] rd_word;

	// ---------------------------------------------------------------
	// Instruction decode
	// ---------------------------------------------------------------
	// Splits the eight-bit code into one of the three supported operations.
	always_comb
	begin
		kind = BMO_K_NONE;
		if (instr_valid_i)
		begin
			if (instr_i == `BMO_INSTR_CLR)
			begin
				kind = BMO_K_CLR;
			end
			else if (instr_i == `BMO_INSTR_SET)
			begin
				kind = BMO_K_SET;
			end
			else if (instr_i[7:4] == `BMO_INSTR_SHL_HI)
			begin
				kind = BMO_K_SHL;
			end
			else
			begin
				kind = BMO_K_BAD;
			end
		end
	end

	// ---------------------------------------------------------------
	// Operand fetch
	// ---------------------------------------------------------------
	// The mask is the two address nibbles; the R read port stays on the R address.
	assign mask = {dest_address_low_i, r_operand_address_low_i};
	assign rf.sa_addr = s_operand_address_i;
	assign rf.ra_addr = {r_operand_address_high_i, r_operand_address_low_i};
	assign rf.ba_addr = reg_addr_i[7:2];
	assign s_word = rf.sa_data;

	bmo_regfile u_rf (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.rf(rf.file)
	);

	// ---------------------------------------------------------------
	// ALU ahead of the shifter
	// ---------------------------------------------------------------
	// The carry input takes part exactly as for the plain operation.
	bmo_alu u_alu (
		.r_i(rf.ra_data),
		.s_i(s_word),
		.op_i(instr_i[3:0]),
		.carry_input_i(carry_input_i),
		.wsize_i(st_ff.wsize),
		.f_o(alu_f),
		.cout_o(alu_cout),
		.ovf_o(alu_ovf)
	);

	// ---------------------------------------------------------------
	// Byte slices: masked bit ops and left shift
	// ---------------------------------------------------------------
	for (genvar b = 0; b < 4; b++)
	begin : g_slice
		// A low shift-I/O line selects the byte for a bit op; others pass S untouched.
		assign sel[b] = ~byte_shift_io_n_i[b];
		// One mask is replicated over every byte.
		assign bit_res[8*b+7:8*b] = !sel[b] ? s_word[8*b+7:8*b]
			: (kind == BMO_K_CLR) ? (s_word[8*b+7:8*b] & ~mask)
			: (s_word[8*b+7:8*b] | mask);
		// Only selected bytes vote on the zero flag.
		assign sel_zero[b] = !sel[b] || (bit_res[8*b+7:8*b] == 8'h00);
		// Bits move up one; the top bit of the word's top byte falls off.
		assign shl_res[8*b+7:8*b+1] = alu_f[8*b+6:8*b];
		if (b == 0)
		begin : g_lsb
			// The lowest byte always starts a word.
			assign shl_res[0] = ~byte_shift_io_n_i[0];
		end
		else
		begin : g_mid
			// A word's lowest byte takes its fill; inner bytes take the bit below.
			assign shl_res[8*b] = bmo_word_lsb(b, st_ff.wsize)
				? ~byte_shift_io_n_i[b]
				: alu_f[8*b-1];
		end
	end

	// ---------------------------------------------------------------
	// Result and flag selection
	// ---------------------------------------------------------------
	// Picks the word that is written back and the flags that go with it.
	always_comb
	begin
		op_res = bit_res;
		op_flags = '0;
		unique case (kind)
			BMO_K_CLR, BMO_K_SET:
			begin
				// Select flag and carry input play no part here.
				op_res = bit_res;
				op_flags[`BMO_FLAG_ZERO] = &sel_zero;
			end
			BMO_K_SHL:
			begin
				// A low select flag keeps the ALU result unshifted.
				op_res = conditional_select_flag_i ? shl_res : alu_f;
				op_flags[`BMO_FLAG_ZERO] = (op_res == 32'h0000_0000);
				op_flags[`BMO_FLAG_NEG] = op_res[31];
				op_flags[`BMO_FLAG_OVF] = alu_ovf | (alu_f[31] ^ alu_f[30]);
				op_flags[`BMO_FLAG_CARRY] = alu_cout;
			end
			BMO_K_NONE, BMO_K_BAD:
			begin
				op_res = bit_res;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Register file write port
	// ---------------------------------------------------------------
	// An instruction write takes the port ahead of a software write in the same cycle.
	assign rf_hit = (reg_addr_i[9:8] == 2'(`BMO_ADDR_RF_BASE >> 8));
	always_comb
	begin
		rf.we = 1'b0;
		rf.wa = s_operand_address_i;
		rf.wd = op_res;
		if (kind == BMO_K_CLR || kind == BMO_K_SET)
		begin
			rf.we = 1'b1;
			rf.wa = s_operand_address_i;
		end
		else if (kind == BMO_K_SHL)
		begin
			rf.we = 1'b1;
			rf.wa = {dest_address_high_i, dest_address_low_i};
		end
		else if (reg_wr_i && rf_hit)
		begin
			rf.we = 1'b1;
			rf.wa = reg_addr_i[7:2];
			rf.wd = reg_wdata_i;
		end
	end

	// ---------------------------------------------------------------
	// Register read mux
	// ---------------------------------------------------------------
	// Unmapped offsets read as zero.
	always_comb
	begin
		rd_word = '0;
		if (rf_hit)
		begin
			rd_word = rf.ba_data;
		end
		else
		begin
			unique case (reg_addr_i)
				`BMO_ADDR_CTRL: rd_word = {30'h0, st_ff.wsize};
				`BMO_ADDR_FLAGS: rd_word = {28'h0, st_ff.flags};
				`BMO_ADDR_IRQ_STAT: rd_word = {29'h0, st_ff.irq_stat};
				`BMO_ADDR_IRQ_MASK: rd_word = {29'h0, st_ff.irq_mask};
				`BMO_ADDR_RESULT: rd_word = st_ff.y;
				default: rd_word = '0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	// Events: completion, overflow on a shift, and an unknown instruction code.
	assign events[`BMO_EV_DONE] = (kind == BMO_K_CLR) || (kind == BMO_K_SET) || (kind == BMO_K_SHL);
	assign events[`BMO_EV_OVF] = (kind == BMO_K_SHL) && op_flags[`BMO_FLAG_OVF];
	assign events[`BMO_EV_BAD] = (kind == BMO_K_BAD);

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.done = events[`BMO_EV_DONE];
		nxt_st.rdata = reg_rd_i ? rd_word : 32'h0000_0000;
		if (events[`BMO_EV_DONE])
		begin
			nxt_st.y = op_res;
			nxt_st.rbus = mask;
			nxt_st.flags = op_flags;
		end
		if (reg_wr_i && reg_addr_i == `BMO_ADDR_CTRL && reg_wdata_i[1:0] != 2'h3)
		begin
			nxt_st.wsize = bmo_wsize_e'(reg_wdata_i[1:0]);
		end
		if (reg_wr_i && reg_addr_i == `BMO_ADDR_IRQ_MASK)
		begin
			nxt_st.irq_mask = reg_wdata_i[2:0];
		end
		// Write-one-to-clear; a new event in the same cycle wins over the clear.
		if (reg_wr_i && reg_addr_i == `BMO_ADDR_IRQ_STAT)
		begin
			nxt_st.irq_stat = st_ff.irq_stat & ~reg_wdata_i[2:0];
		end
		nxt_st.irq_stat = nxt_st.irq_stat | events;
	end

	// State register; reset loads constants only.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			st_ff <= '0;
			st_ff.irq_mask <= `BMO_IRQ_MASK_RST;
			st_ff.wsize <= bmo_wsize_e'(`BMO_WSIZE_RST);
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign y_o = st_ff.y;
	assign rbus_o = st_ff.rbus;
	assign zero_flag_o = st_ff.flags[`BMO_FLAG_ZERO];
	assign negative_flag_o = st_ff.flags[`BMO_FLAG_NEG];
	assign overflow_flag_o = st_ff.flags[`BMO_FLAG_OVF];
	assign carry_flag_o = st_ff.flags[`BMO_FLAG_CARRY];
	assign done_o = st_ff.done;
	assign reg_rdata_o = st_ff.rdata;
	// Level interrupt while any unmasked status bit is set.
	assign irq_o = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule

// ### include/bmo_consts.svh
// Register offsets, field positions, reset values and decode codes of the bit-op ALU slice.
`ifndef BMO_CONSTS_SVH
`define BMO_CONSTS_SVH

// ---------------------------------------------------------------
// Register map (byte addresses on the 10-bit register port)
// ---------------------------------------------------------------
`define BMO_ADDR_CTRL 10'h000
`define BMO_ADDR_FLAGS 10'h004
`define BMO_ADDR_IRQ_STAT 10'h008
`define BMO_ADDR_IRQ_MASK 10'h00c
`define BMO_ADDR_RESULT 10'h010
`define BMO_ADDR_RF_BASE 10'h100

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define BMO_FLAG_ZERO 0
`define BMO_FLAG_NEG 1
`define BMO_FLAG_OVF 2
`define BMO_FLAG_CARRY 3
`define BMO_EV_DONE 0
`define BMO_EV_OVF 1
`define BMO_EV_BAD 2
`define BMO_IRQ_MASK_RST 3'h0
`define BMO_WSIZE_RST 2'h2

// ---------------------------------------------------------------
// Instruction codes
// ---------------------------------------------------------------
`define BMO_INSTR_CLR 8'h18
`define BMO_INSTR_SET 8'h08
`define BMO_INSTR_SHL_HI 4'h6

`endif

// ### include/bmo_pkg.sv
// Types and shared decode functions of the bit-op ALU slice.
package bmo_pkg;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {BMO_W8, BMO_W16, BMO_W32} bmo_wsize_e;
	typedef enum logic [2:0] {BMO_K_NONE, BMO_K_CLR, BMO_K_SET, BMO_K_SHL, BMO_K_BAD} bmo_kind_e;

	typedef struct packed {
		logic [31:0] y;
		logic [7:0] rbus;
		logic [3:0] flags;
		logic done;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		bmo_wsize_e wsize;
		logic [31:0] rdata;
	} bmo_top_s;

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	// True when byte b is the least significant byte of its word.
	function automatic logic bmo_word_lsb(input int unsigned b, input bmo_wsize_e ws);
		unique case (ws)
			BMO_W8: return 1'b1;
			BMO_W16: return (b % 2) == 0;
			BMO_W32: return b == 0;
			default: return b == 0;
		endcase
	endfunction

endpackage

// ### include/bmo_rf_if.sv
// Register-file port bundle between the slice core and its register file.
interface bmo_rf_if;
	logic [5:0] ra_addr;
	logic [31:0] ra_data;
	logic [5:0] sa_addr;
	logic [31:0] sa_data;
	logic [5:0] ba_addr;
	logic [31:0] ba_data;
	logic we;
	logic [5:0] wa;
	logic [31:0] wd;

	modport core (output ra_addr, sa_addr, ba_addr, we, wa, wd, input ra_data, sa_data, ba_data);
	modport file (input ra_addr, sa_addr, ba_addr, we, wa, wd, output ra_data, sa_data, ba_data);
endinterface
